// >>> rtc_pkg.sv
// Purpose: Shared constants for the clock support block
// Assumes: 100 MHz core clock, 32.768 kHz oscillator on a pin
// Notes: Indices, fields, control and config resets and timing counts live here; top derives UIP_START and LEAD_CNT
package rtc_pkg;
  // Host port codes
  localparam logic [1:0] PORT_STD_IDX = 2'h0;
  localparam logic [1:0] PORT_STD_DATA = 2'h1;
  localparam logic [1:0] PORT_EXT_IDX = 2'h2;
  localparam logic [1:0] PORT_EXT_DATA = 2'h3;
  // Standard RAM indices
  localparam logic [6:0] IDX_CRA = 7'h0a;
  localparam logic [6:0] IDX_CRB = 7'h0b;
  localparam logic [6:0] IDX_CRC = 7'h0c;
  localparam logic [6:0] IDX_CRD = 7'h0d;
  localparam logic [6:0] IDX_GENERAL = 7'h0e;
  // Configuration indices and reset
  localparam logic [7:0] CFG_RAM_LOCK = 8'hf0;
  localparam logic [7:0] CFG_DAY_LOC = 8'hf1;
  localparam logic [7:0] CFG_MON_LOC = 8'hf2;
  localparam logic [7:0] CFG_CENT_LOC = 8'hf3;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Field positions
  localparam int PER_BIT = 6;
  localparam int ALM_BIT = 5;
  localparam int UPD_BIT = 4;
  localparam int LOCK_STD_BIT = 0;
  localparam int LOCK_EXT_BIT = 1;
  // Control register resets and divider patterns
  localparam logic [7:0] CRB_RESET = 8'h00;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [3:0] RATE_RESET = 4'h0;
  localparam logic [2:0] DIV_STOP = 3'h0;
  localparam logic [2:0] DIV_NORMAL = 3'h2;
  localparam logic [14:0] DIV_START = 15'h4000;
  // Timing
  localparam int CLK_NS = 10;
  localparam int LOCK_MIN_MS = 62;
  localparam int LOCK_MAX_MS = 125;
  localparam int LOCK_MIN_CYC = (LOCK_MIN_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_MAX_CYC = (LOCK_MAX_MS * 1000000) / CLK_NS;
  localparam real TICK_US = 30.5;
  localparam real UIP_LEAD_US = 244.0;
  localparam real ALARM_DELAY_US = 30.5;
  localparam int UIP_LEAD_TICKS = int'(UIP_LEAD_US / TICK_US);
  localparam int ALARM_DELAY_TICKS = int'(ALARM_DELAY_US / TICK_US);
  // Lockout states
  typedef enum logic [1:0] {LK_OFF, LK_DELAY, LK_OPEN} lock_state_t;
endpackage : rtc_pkg

// >>> rtc_lock_if.sv
// Purpose: Supply status and lockout group
// Assumes: Inputs already synchronised
// Notes: ctrl is the lockout unit, user the main block
`timescale 1ns/1ps
interface rtc_lock_if;
  logic standby_on;
  logic standby_off;
  logic battery_detect;
  logic host_bus_reset_n;
  logic div_normal;
  logic valid_ram_time;
  logic standby_good;
  logic inputs_open;
  logic init_pulse;
  modport ctrl (
    input standby_on, standby_off, battery_detect, host_bus_reset_n, div_normal, valid_ram_time,
    output standby_good, inputs_open, init_pulse
  );
  modport user (
    output standby_on, standby_off, battery_detect, host_bus_reset_n, div_normal, valid_ram_time,
    input standby_good, inputs_open, init_pulse
  );
endinterface : rtc_lock_if

// >>> rtc_power_lockout.sv
// Purpose: Standby detection and host input lockout
// Assumes: Supply levels synchronised by the caller
// Notes: LOCK_CYCLES may be shortened for simulation
`timescale 1ns/1ps
module rtc_power_lockout
  import rtc_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = LOCK_MIN_CYC
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Supply and lockout group
  rtc_lock_if.ctrl lk
);
  if (LOCK_CYCLES < 1 || LOCK_CYCLES > LOCK_MAX_CYC)
  begin : g_bad_lock
    $error("LOCK_CYCLES out of range");
  end

  lock_state_t state_reg;
  lock_state_t state_next;
  logic sb_good_reg;
  logic sb_good_next;
  logic [23:0] wait_reg;
  logic [23:0] wait_next;
  logic early_w;
  logic wait_done_w;

  assign sb_good_next = sb_good_reg ? lk.standby_off : lk.standby_on;
  assign early_w = lk.div_normal | (!lk.battery_detect & !lk.host_bus_reset_n)
                   | !lk.valid_ram_time;
  assign wait_done_w = wait_reg == 24'(LOCK_CYCLES - 1);
  assign wait_next = (state_reg == LK_DELAY) ? wait_reg + 24'h1 : 24'h0;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      LK_OFF:
      begin
        if (sb_good_reg)
        begin
          state_next = early_w ? LK_OPEN : LK_DELAY;
        end
      end
      LK_DELAY:
      begin
        if (!sb_good_reg)
        begin
          state_next = LK_OFF;
        end
        else if (early_w || wait_done_w)
        begin
          state_next = LK_OPEN;
        end
      end
      default:
      begin
        if (!sb_good_reg)
        begin
          state_next = LK_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= LK_OFF;
      sb_good_reg <= 1'b0;
      wait_reg <= 24'h0;
    end
    else
    begin
      state_reg <= state_next;
      sb_good_reg <= sb_good_next;
      wait_reg <= wait_next;
    end
  end

  assign lk.standby_good = sb_good_reg;
  assign lk.inputs_open = (state_reg == LK_OPEN) && sb_good_reg;
  assign lk.init_pulse = (state_reg == LK_OFF) && sb_good_reg && !lk.battery_detect
                         && !lk.host_bus_reset_n;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  chk_low_locks: assert property (!sb_good_reg |-> !lk.inputs_open)
    else $error("Inputs open without standby");
  chk_lock_held: assert property (
    state_reg == LK_DELAY && sb_good_reg && !early_w && !wait_done_w |=> !lk.inputs_open)
    else $error("Lockout released early");
  chk_delay_end: assert property (
    state_reg == LK_DELAY && sb_good_reg && sb_good_next && wait_done_w |=> lk.inputs_open)
    else $error("Lockout not released at delay end");
  chk_early_open: assert property (
    state_reg == LK_OFF && sb_good_reg && sb_good_next && early_w |=> lk.inputs_open)
    else $error("Early release missed");
endmodule : rtc_power_lockout

// >>> rtc_irq_flags.sv
// Purpose: Sticky event flags merged onto one request
// Assumes: Set and clear pulses on the core clock
// Notes: A set in the clearing cycle survives
`timescale 1ns/1ps
module rtc_irq_flags
#(
  parameter int NUM = 3
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Events and enables
  input wire logic [NUM-1:0] set_i,
  input wire logic [NUM-1:0] enable_i,
  input wire logic clear_i,
  // Status
  output logic [NUM-1:0] flags_o,
  output logic irq_o
);
  if (NUM < 1)
  begin : g_bad_num
    $error("NUM must be positive");
  end

  logic [NUM-1:0] flag_reg;
  logic [NUM-1:0] pend_reg;

  for (genvar i = 0; i < NUM; i++)
  begin : g_flag
    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
      begin
        flag_reg[i] <= 1'b0;
        pend_reg[i] <= 1'b0;
      end
      else
      begin
        flag_reg[i] <= (flag_reg[i] & !clear_i) | set_i[i];
        pend_reg[i] <= (pend_reg[i] & !clear_i) | (set_i[i] & enable_i[i]);
      end
    end
  end

  assign flags_o = flag_reg;
  assign irq_o = |(pend_reg & enable_i);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  chk_flag_clear: assert property (
    clear_i && set_i == '0 |=> flags_o == '0 && !irq_o)
    else $error("Flags not cleared by read");
  chk_irq_gate: assert property (irq_o |-> |(flags_o & enable_i))
    else $error("Request without enabled flag");
  chk_set_wins: assert property (
    |set_i |=> (flags_o & $past(set_i)) == $past(set_i))
    else $error("Event lost");
endmodule : rtc_irq_flags

// >>> rtc_support_top.sv
// Purpose: Clock support logic: lockout, events, RAM ports
// Assumes: Timekeeping counters outside; they report alarm match
// Notes: Supply detector levels and oscillator are asynchronous pins
`timescale 1ns/1ps
// Notes on behaviour
// - Host inputs ignored while standby is below its on or off threshold.
// - After battery to standby switch, lockout lasts 62 to 125 ms.
// - Divider control at normal pattern releases lockout at once.
// - Low battery with host reset low releases at once, clears 00h-09h and resets registers A and B.
// - Valid RAM and time bit clear releases lockout at once.
// - Oscillator runs with standby good or battery above minimum.
// - Divider control all zeros plus no standby stops the oscillator.
// - Stopped oscillator means no updates, periodic or alarm events.
// - One request output shared by periodic, alarm and update-ended events.
// - A source requests only if its enable was set before the event.
// - Reading control register C clears all flags; reset clears them too.
// - A repeated event while pending leaves one pending flag.
// - Update-in-progress rises 244 us before each update.
// - Alarm flag set 30.5 us after the matching update ends.
// - Periodic event precedes update by half period plus the lead time.
// - First 14 bytes are registers; remaining bytes are general storage.
// - Index port at base selects; data port at base plus one transfers.
// - Second index and data pair reaches 128 extended bytes.
// - Configuration access refused on battery alone.
// - Write-one-to-set bits change only where a one is written.
// - Lock at F0h, location registers F1h-F3h, all reset to 00h.
// - Control register B bits 6, 5, 4 enable periodic, alarm, update.
// - Control register C bit 5 is alarm, bit 4 update-ended.
module rtc_support_top
  import rtc_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = LOCK_MIN_CYC
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Supply detectors and host reset pin
  input wire logic standby_on_i,
  input wire logic standby_off_i,
  input wire logic battery_min_i,
  input wire logic battery_detect_i,
  input wire logic main_power_i,
  input wire logic host_bus_reset_n_i,
  // Oscillator
  input wire logic osc_32k_i,
  output logic osc_enable_o,
  // Host index and data ports
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [1:0] io_port_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // Configuration access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_index_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  // Timekeeping side
  input wire logic alarm_match_i,
  output logic update_strobe_o,
  output logic [7:0] day_alarm_location_o,
  output logic [7:0] month_alarm_location_o,
  output logic [7:0] century_location_o,
  // Interrupt request
  output logic irq_o
);
  localparam logic [14:0] UIP_START = 15'(16'h8000 - 16'(UIP_LEAD_TICKS));
  localparam logic [14:0] LEAD_CNT = 15'(UIP_LEAD_TICKS);

  if (ALARM_DELAY_TICKS != 1)
  begin : g_bad_alarm
    $error("Alarm delay must be one tick");
  end

  // Pin synchronisers
  logic [6:0] pin_w;
  logic [6:0] pin_meta_reg;
  logic [6:0] pin_sync_reg;
  logic osc_prev_reg;

  assign pin_w = {osc_32k_i, host_bus_reset_n_i, main_power_i, battery_detect_i,
                  battery_min_i, standby_off_i, standby_on_i};

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pin_meta_reg <= 7'h00;
      pin_sync_reg <= 7'h00;
      osc_prev_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= pin_w;
      pin_sync_reg <= pin_meta_reg;
      osc_prev_reg <= pin_sync_reg[6];
    end
  end

  // State
  logic [6:0] std_idx_reg;
  logic [6:0] ext_idx_reg;
  logic [7:0] std_ram [0:127];
  logic [7:0] ext_ram [0:127];
  logic [2:0] cra_div_reg;
  logic [3:0] cra_rate_reg;
  logic [7:0] crb_reg;
  logic vrt_reg;
  logic [7:0] ram_lock_reg;
  logic [7:0] day_loc_reg;
  logic [7:0] mon_loc_reg;
  logic [7:0] cent_loc_reg;
  logic [14:0] cnt_reg;
  logic [14:0] cnt_next;
  logic alarm_wait_reg;
  logic alarm_wait_next;
  logic [7:0] io_rdata_reg;
  logic [7:0] cfg_rdata_reg;
  logic osc_en_reg;
  logic update_reg;

  // Lockout unit
  rtc_lock_if lk ();

  assign lk.standby_on = pin_sync_reg[0];
  assign lk.standby_off = pin_sync_reg[1];
  assign lk.battery_detect = pin_sync_reg[3];
  assign lk.host_bus_reset_n = pin_sync_reg[5];
  assign lk.div_normal = cra_div_reg == DIV_NORMAL;
  assign lk.valid_ram_time = vrt_reg;

  rtc_power_lockout #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_lockout (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .lk(lk.ctrl)
  );

  // Host decode
  logic hw;
  logic hr;
  logic sel_std_idx;
  logic sel_std_data;
  logic sel_ext_idx;
  logic sel_ext_data;
  logic is_cra;
  logic is_crb;
  logic is_crc;
  logic is_crd;
  logic is_reg;
  logic std_locked;
  logic ext_locked;
  logic std_ram_we;
  logic ext_ram_we;
  logic crc_clear;

  assign hw = io_wr_i & lk.inputs_open;
  assign hr = io_rd_i & lk.inputs_open;
  assign sel_std_idx = io_port_i == PORT_STD_IDX;
  assign sel_std_data = io_port_i == PORT_STD_DATA;
  assign sel_ext_idx = io_port_i == PORT_EXT_IDX;
  assign sel_ext_data = io_port_i == PORT_EXT_DATA;
  assign is_cra = std_idx_reg == IDX_CRA;
  assign is_crb = std_idx_reg == IDX_CRB;
  assign is_crc = std_idx_reg == IDX_CRC;
  assign is_crd = std_idx_reg == IDX_CRD;
  assign is_reg = is_cra | is_crb | is_crc | is_crd;
  assign std_locked = ram_lock_reg[LOCK_STD_BIT] && std_idx_reg >= IDX_GENERAL;
  assign ext_locked = ram_lock_reg[LOCK_EXT_BIT];
  assign std_ram_we = hw & sel_std_data & !is_reg & !std_locked;
  assign ext_ram_we = hw & sel_ext_data & !ext_locked;
  assign crc_clear = hr & sel_std_data & is_crc;

  // Event timing
  logic tick;
  logic osc_run;
  logic run_tick;
  logic update_start;
  logic uip;
  logic [3:0] per_shift;
  logic [14:0] per_mask;
  logic [14:0] per_half;
  logic per_hit;
  logic alarm_fire;
  logic [2:0] ev_set;
  logic [2:0] ev_en;
  logic [2:0] flags;
  logic irq_w;

  assign tick = pin_sync_reg[6] & !osc_prev_reg;
  assign osc_run = lk.standby_good | (pin_sync_reg[2] & (cra_div_reg != DIV_STOP));
  assign run_tick = tick & osc_run & (cra_div_reg == DIV_NORMAL);
  assign update_start = run_tick & (cnt_reg == 15'h7fff);
  assign uip = (cnt_reg >= UIP_START) & (cra_div_reg == DIV_NORMAL) & osc_run;
  assign per_shift = (cra_rate_reg < 4'h3) ? cra_rate_reg + 4'h6 : cra_rate_reg - 4'h1;
  assign per_mask = (15'h1 << per_shift) - 15'h1;
  assign per_half = 15'h1 << (per_shift - 4'h1);
  assign per_hit = run_tick & (cra_rate_reg != 4'h0)
                   & ((15'(cnt_reg + per_half + LEAD_CNT) & per_mask) == 15'h0);
  assign alarm_fire = alarm_wait_reg & run_tick;
  assign alarm_wait_next = (alarm_wait_reg & !run_tick) | (update_start & alarm_match_i);
  assign cnt_next = (cra_div_reg != DIV_NORMAL) ? DIV_START
                    : (run_tick ? cnt_reg + 15'h1 : cnt_reg);
  assign ev_set = {per_hit, alarm_fire, update_start};
  assign ev_en = {crb_reg[PER_BIT], crb_reg[ALM_BIT], crb_reg[UPD_BIT]};

  rtc_irq_flags #(
    .NUM(3)
  ) u_flags (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .set_i(ev_set),
    .enable_i(ev_en),
    .clear_i(crc_clear),
    .flags_o(flags),
    .irq_o(irq_w)
  );

  // Read values
  logic [7:0] cra_val;
  logic [7:0] crc_val;
  logic [7:0] std_rd;
  logic [7:0] io_rd;
  logic cfg_ok;
  logic [7:0] cfg_rd;

  assign cra_val = {uip, cra_div_reg, cra_rate_reg};
  assign crc_val = {irq_w, flags, 4'h0};
  assign std_rd = is_cra ? cra_val : is_crb ? crb_reg : is_crc ? crc_val
                  : is_crd ? {vrt_reg, 7'h00} : std_locked ? 8'h00 : std_ram[std_idx_reg];
  assign io_rd = sel_std_idx ? {1'b0, std_idx_reg} : sel_std_data ? std_rd
                 : sel_ext_idx ? {1'b0, ext_idx_reg}
                 : (ext_locked ? 8'h00 : ext_ram[ext_idx_reg]);
  assign cfg_ok = lk.standby_good | pin_sync_reg[4];
  assign cfg_rd = (cfg_index_i == CFG_RAM_LOCK) ? ram_lock_reg
                  : (cfg_index_i == CFG_DAY_LOC) ? day_loc_reg
                  : (cfg_index_i == CFG_MON_LOC) ? mon_loc_reg
                  : (cfg_index_i == CFG_CENT_LOC) ? cent_loc_reg : 8'h00;

  // RAM arrays, battery backed and not reset
  always_ff @(posedge core_clk_i)
  begin
    if (lk.init_pulse)
    begin
      for (int i = 0; i < int'(IDX_CRA); i++)
      begin
        std_ram[i] <= 8'h00;
      end
    end
    else if (std_ram_we)
    begin
      std_ram[std_idx_reg] <= io_wdata_i;
    end
    if (ext_ram_we)
    begin
      ext_ram[ext_idx_reg] <= io_wdata_i;
    end
  end

  // Index and control registers
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || lk.init_pulse)
    begin
      cra_div_reg <= DIV_RESET;
      cra_rate_reg <= RATE_RESET;
      crb_reg <= CRB_RESET;
    end
    else if (hw && sel_std_data && is_cra)
    begin
      {cra_div_reg, cra_rate_reg} <= io_wdata_i[6:0];
    end
    else if (hw && sel_std_data && is_crb)
    begin
      crb_reg <= io_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      std_idx_reg <= 7'h00;
      ext_idx_reg <= 7'h00;
      vrt_reg <= 1'b0;
      cnt_reg <= DIV_START;
      alarm_wait_reg <= 1'b0;
      osc_en_reg <= 1'b0;
      update_reg <= 1'b0;
    end
    else
    begin
      std_idx_reg <= (hw && sel_std_idx) ? io_wdata_i[6:0] : std_idx_reg;
      ext_idx_reg <= (hw && sel_ext_idx) ? io_wdata_i[6:0] : ext_idx_reg;
      vrt_reg <= pin_sync_reg[3] & (vrt_reg | (hr & sel_std_data & is_crd));
      cnt_reg <= cnt_next;
      alarm_wait_reg <= alarm_wait_next;
      osc_en_reg <= osc_run;
      update_reg <= update_start;
    end
  end

  // Configuration registers and read data
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ram_lock_reg <= CFG_RESET;
      day_loc_reg <= CFG_RESET;
      mon_loc_reg <= CFG_RESET;
      cent_loc_reg <= CFG_RESET;
      io_rdata_reg <= 8'h00;
      cfg_rdata_reg <= 8'h00;
    end
    else
    begin
      if (cfg_wr_i && cfg_ok)
      begin
        if (cfg_index_i == CFG_RAM_LOCK)
        begin
          ram_lock_reg <= ram_lock_reg | cfg_wdata_i;
        end
        else if (cfg_index_i == CFG_DAY_LOC)
        begin
          day_loc_reg <= cfg_wdata_i;
        end
        else if (cfg_index_i == CFG_MON_LOC)
        begin
          mon_loc_reg <= cfg_wdata_i;
        end
        else if (cfg_index_i == CFG_CENT_LOC)
        begin
          cent_loc_reg <= cfg_wdata_i;
        end
      end
      if (cfg_rd_i)
      begin
        cfg_rdata_reg <= cfg_ok ? cfg_rd : 8'h00;
      end
      if (io_rd_i)
      begin
        io_rdata_reg <= hr ? io_rd : 8'h00;
      end
    end
  end

  assign io_rdata_o = io_rdata_reg;
  assign cfg_rdata_o = cfg_rdata_reg;
  assign osc_enable_o = osc_en_reg;
  assign update_strobe_o = update_reg;
  assign day_alarm_location_o = day_loc_reg;
  assign month_alarm_location_o = mon_loc_reg;
  assign century_location_o = cent_loc_reg;
  assign irq_o = irq_w;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_update_match;
    update_start && alarm_match_i;
  endsequence

  chk_alarm_arm: assert property (s_update_match |=> alarm_wait_reg)
    else $error("Alarm not armed by matching update");
  chk_alarm_fire: assert property (alarm_wait_reg && run_tick |=> flags[1])
    else $error("Alarm flag not raised one tick after update");
  chk_uip_rise: assert property (
    run_tick && cnt_reg == 15'(UIP_START - 15'h1) |=> uip)
    else $error("Update-in-progress late");
  chk_uip_update: assert property (update_start |-> uip && cnt_reg >= UIP_START)
    else $error("Update without progress bit");
  chk_osc_quiet: assert property (!osc_run && !crc_clear |=> flags == $past(flags))
    else $error("Event while oscillator stopped");
  chk_lock_guard: assert property (
    io_wr_i && !lk.inputs_open && !lk.init_pulse |=> $stable(crb_reg) && $stable(std_idx_reg))
    else $error("Write taken during lockout");
  chk_cfg_refuse: assert property (
    cfg_wr_i && !cfg_ok |=> $stable(ram_lock_reg) && $stable(day_loc_reg))
    else $error("Configuration write on battery");
  chk_crc_read: assert property (
    crc_clear && ev_set == 3'h0 |=> io_rdata_o == $past(crc_val) && flags == 3'h0)
    else $error("Flag read did not clear");
  chk_lock_sticky: assert property (
    ram_lock_reg[LOCK_STD_BIT] |=> ram_lock_reg[LOCK_STD_BIT])
    else $error("RAM lock dropped");
endmodule : rtc_support_top

// >>> rtc_host_model.sv
// Purpose: Host controller model for port and config cycles
// Assumes: Strobes last one cycle and start 1 ns after an edge
// Notes: Released data lines carry the inverse of the last value
`timescale 1ns/1ps
module rtc_host_model
  import rtc_pkg::*;
(
  // Clock
  input wire logic core_clk_i,
  // Host ports
  output logic io_wr_o,
  output logic io_rd_o,
  output logic [1:0] io_port_o,
  output logic [7:0] io_wdata_o,
  input wire logic [7:0] io_rdata_i,
  // Config port
  output logic cfg_wr_o,
  output logic cfg_rd_o,
  output logic [7:0] cfg_index_o,
  output logic [7:0] cfg_wdata_o,
  input wire logic [7:0] cfg_rdata_i
);
  initial
  begin
    {cfg_wr_o, cfg_rd_o, io_wr_o, io_rd_o} = 4'h0;
    io_port_o = 2'h0;
    io_wdata_o = 8'h00;
    cfg_index_o = 8'h00;
    cfg_wdata_o = 8'h00;
  end
  task automatic bus(input logic cfg, input logic wr, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk_i);
    #1;
    io_port_o = a[1:0];
    cfg_index_o = a;
    io_wdata_o = d;
    cfg_wdata_o = d;
    {cfg_wr_o, cfg_rd_o, io_wr_o, io_rd_o} = cfg ? {wr, !wr, 2'b00} : {2'b00, wr, !wr};
    @(posedge core_clk_i);
    #1;
    {cfg_wr_o, cfg_rd_o, io_wr_o, io_rd_o} = 4'h0;
    io_wdata_o = ~d;
    cfg_wdata_o = ~d;
    @(posedge core_clk_i);
    #1;
    q = cfg ? cfg_rdata_i : io_rdata_i;
  endtask : bus
  // Index first, then data
  task automatic access(input logic ext, input logic [6:0] idx, input logic wr,
    input logic [7:0] d, output logic [7:0] q);
    bus(1'b0, 1'b1, {6'h00, ext ? PORT_EXT_IDX : PORT_STD_IDX}, {1'b0, idx}, q);
    bus(1'b0, wr, {6'h00, ext ? PORT_EXT_DATA : PORT_STD_DATA}, d, q);
  endtask : access
endmodule : rtc_host_model

// >>> rtc_support_top_tb.sv
// Purpose: Self-checking bench for the clock support top
// Assumes: Oscillator pin toggled only for the periodic event test
// Notes: Lockout delay shortened to 20 cycles
`timescale 1ns/1ps
module rtc_support_top_tb;
  import rtc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic stby = 1'b1;
  logic batt_min = 1'b0;
  logic main_pwr = 1'b0;
  logic osc = 1'b0;
  logic batt_det = 1'b1;
  logic host_rst_n = 1'b1;
  logic [7:0] cent_exp;
  logic io_wr, io_rd, cfg_wr, cfg_rd, osc_en, upd, irq;
  logic [1:0] io_port;
  logic [7:0] io_wdata, io_rdata, cfg_index, cfg_wdata, cfg_rdata, cent, q, lock;
  logic [7:0] vals [4] = '{8'h00, 8'h01, 8'h00, 8'h02};
  logic [6:0] idx;
  logic [31:0] seed = 32'h3d445ae0;
  int error_cnt = 0;
  int compares = 0;
  always #5 core_clk_i = ~core_clk_i;
  rtc_support_top #(.LOCK_CYCLES(20)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .standby_on_i(stby), .standby_off_i(stby), .battery_min_i(batt_min),
    .battery_detect_i(batt_det), .main_power_i(main_pwr), .host_bus_reset_n_i(host_rst_n),
    .osc_32k_i(osc), .osc_enable_o(osc_en), .io_wr_i(io_wr), .io_rd_i(io_rd),
    .io_port_i(io_port), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
    .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_index_i(cfg_index),
    .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata), .alarm_match_i(1'b0),
    .update_strobe_o(upd), .day_alarm_location_o(), .month_alarm_location_o(),
    .century_location_o(cent), .irq_o(irq));
  rtc_host_model host (.core_clk_i(core_clk_i), .io_wr_o(io_wr), .io_rd_o(io_rd),
    .io_port_o(io_port), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata),
    .cfg_wr_o(cfg_wr), .cfg_rd_o(cfg_rd), .cfg_index_o(cfg_index),
    .cfg_wdata_o(cfg_wdata), .cfg_rdata_i(cfg_rdata));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Write-one-to-set result
  function automatic logic [7:0] w1s(input logic [7:0] old, input logic [7:0] wv);
    return old | wv;
  endfunction : w1s
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    for (int i = 0; i < 4; i++)
    begin
      host.bus(1'b1, 1'b0, CFG_RAM_LOCK + 8'(i), 8'h00, q);
      chk(q, CFG_RESET);
      if (i > 0)
      begin
        seed = lfsr(seed);
        host.bus(1'b1, 1'b1, CFG_RAM_LOCK + 8'(i), seed[7:0], q);
        host.bus(1'b1, 1'b0, CFG_RAM_LOCK + 8'(i), 8'h00, q);
        chk(q, seed[7:0]);
      end
    end
    cent_exp = seed[7:0];
    chk(cent, cent_exp);
    $display("test config done");
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      idx = (i == 0) ? IDX_GENERAL : (i == 1) ? 7'h7f : 7'h0e + 7'(seed[14:8] % 114);
      host.access(1'b0, idx, 1'b1, seed[7:0], q);
      host.access(1'b1, seed[22:16], 1'b1, ~seed[7:0], q);
      host.access(1'b0, idx, 1'b0, 8'h00, q);
      chk(q, seed[7:0]);
      host.access(1'b1, seed[22:16], 1'b0, 8'h00, q);
      chk(q, ~seed[7:0]);
    end
    host.access(1'b0, IDX_CRB, 1'b1, 8'h70, q);
    host.access(1'b0, IDX_CRB, 1'b0, 8'h00, q);
    chk(q, 8'h70);
    host.access(1'b0, IDX_CRC, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    chk({7'h00, irq}, 8'h00);
    host.access(1'b0, IDX_CRA, 1'b0, 8'h00, q);
    host.access(1'b0, IDX_CRA, 1'b1, {q[7], 7'h23}, q);
    repeat (16)
    begin
      repeat (4) @(posedge core_clk_i);
      #1 osc = ~osc;
    end
    chk({7'h00, irq}, 8'h01);
    host.access(1'b0, IDX_CRC, 1'b0, 8'h00, q);
    chk(q, 8'hc0);
    chk({7'h00, irq}, 8'h00);
    host.access(1'b0, IDX_CRC, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    $display("test ram done");
    lock = CFG_RESET;
    foreach (vals[j])
    begin
      host.bus(1'b1, 1'b1, CFG_RAM_LOCK, vals[j], q);
      lock = w1s(lock, vals[j]);
      host.bus(1'b1, 1'b0, CFG_RAM_LOCK, 8'h00, q);
      chk(q, lock);
    end
    host.access(1'b0, IDX_GENERAL, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    host.access(1'b1, 7'h00, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    $display("test lock done");
    stby = 1'b0;
    repeat (6) @(posedge core_clk_i);
    #1 chk({7'h00, osc_en}, 8'h00);
    batt_min = 1'b1;
    repeat (6) @(posedge core_clk_i);
    #1 chk({7'h00, osc_en}, 8'h01);
    host.bus(1'b1, 1'b1, CFG_CENT_LOC, ~cent, q);
    host.bus(1'b1, 1'b0, CFG_CENT_LOC, 8'h00, q);
    chk(q, 8'h00);
    host.access(1'b0, IDX_CRB, 1'b1, 8'h00, q);
    host.access(1'b0, IDX_CRB, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    #1 stby = 1'b1;
    repeat (8) @(posedge core_clk_i);
    host.access(1'b0, IDX_CRB, 1'b0, 8'h00, q);
    chk(q, 8'h70);
    host.bus(1'b1, 1'b0, CFG_CENT_LOC, 8'h00, q);
    chk(q, cent_exp);
    host.access(1'b0, IDX_CRA, 1'b1, 8'h00, q);
    host.access(1'b0, IDX_CRD, 1'b0, 8'h00, q);
    host.access(1'b0, IDX_CRD, 1'b0, 8'h00, q);
    chk(q, 8'h80);
    stby = 1'b0;
    repeat (6) @(posedge core_clk_i);
    #1 chk({7'h00, osc_en}, 8'h00);
    stby = 1'b1;
    repeat (8) @(posedge core_clk_i);
    host.access(1'b0, IDX_CRB, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    repeat (20) @(posedge core_clk_i);
    host.access(1'b0, IDX_CRB, 1'b0, 8'h00, q);
    chk(q, 8'h70);
    batt_det = 1'b0;
    host_rst_n = 1'b0;
    stby = 1'b0;
    repeat (6) @(posedge core_clk_i);
    #1 stby = 1'b1;
    repeat (8) @(posedge core_clk_i);
    host.access(1'b0, IDX_CRB, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    host.access(1'b0, 7'h00, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    batt_det = 1'b1;
    host_rst_n = 1'b1;
    $display("test supply done");
    #1 rst_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    host.bus(1'b1, 1'b0, CFG_RAM_LOCK, 8'h00, q);
    chk(q, CFG_RESET);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : rtc_support_top_tb
